//--- vcs_consts.svh
`ifndef VCS_CONSTS_SVH
`define VCS_CONSTS_SVH

// Line-count windows, normal field rate
`define VCS_WIN_MIN       10'd448
`define VCS_WIN_MAX       10'd740
`define VCS_STD_625       10'd625
`define VCS_STD_525       10'd525
// Line-count windows, double field rate (halved)
`define VCS_WIN_MIN_2X    10'd224
`define VCS_WIN_MAX_2X    10'd370
`define VCS_STD_625_2X    10'd312
`define VCS_STD_525_2X    10'd262
// Sync separator
`define VCS_SEP_MAX       8'hFF
`define VCS_SEP_THRESH    8'hC8
// Coincidence counter
`define VCS_COIN_FULL     4'h8
`define VCS_COIN_ZERO     4'h0
// Vertical blanking lengths in lines
`define VCS_BLANK_525     10'd20
`define VCS_BLANK_625     10'd25
// Ramp scaling: 1.2 = 6/5, 75% = 3/4
`define VCS_H525_NUM      10'd6
`define VCS_H525_DEN      10'd5
`define VCS_CMP_NUM       10'd3
`define VCS_CMP_SHIFT     2
// Geometry latches
`define VCS_GEO_COUNT     7
`define VCS_GEO_HEIGHT    3'd0

`endif

//--- vcs_pkg.sv
package vcs_pkg;

  typedef enum logic [1:0] {
    VCS_ST_INJECT,
    VCS_ST_COUNTDOWN,
    VCS_ST_FORCED
  } vcs_state_t;

  typedef struct packed {
    logic auto_countdown;
    logic force_inject;
    logic force_625;
    logic force_525;
    logic double_rate;
    logic blank_525;
    logic vertical_compress_select;
    logic interlace_suppress_a;
    logic interlace_suppress_b;
  } vcs_ctrl_t;

  typedef struct packed {
    logic countdown_lock;
    logic h_unlock;
    logic beam_excess;
    logic beam_overload;
    logic std_525;
    logic countdown_mode;
  } vcs_status_t;

  typedef struct packed {
    logic [5:0] tilt;
    logic [5:0] corner;
    logic [5:0] parabola_amp;
    logic [5:0] position;
    logic [5:0] breathing;
    logic [5:0] linearity;
    logic [5:0] amplitude;
  } vcs_geo_t;

endpackage

//--- vcs_top.sv
// Functional notes
// - Separator counts up on sync high, down otherwise
// - Vertical sync only above broad-pulse threshold
// - Auto countdown starts in injection lock
// - Injection lock syncs to first vertical pulse
// - Matching field count increments coincidence counter
// - Eight coincidences engage countdown; MSB is flag
// - Mismatches decrement; zero reverts to injection lock
// - Host command forces injection lock immediately
// - Injection lock ignores sync before line 448
// - Line 740 without sync forces reset
// - Double rate halves end-stops; no 120 Hz
// - Forced 625 or 525 count ignores sync
// - 525 standard scales height by 1.2
// - Compression bit reduces amplitude to 75%
// - Each geometry control has a 6-bit latch
// - First beam threshold sets excess flag
// - Second beam threshold sets overload flag
// - Host bit selects 525 or 625 blanking
// - Two host bits suppress interlace
// - Report horizontal out-of-lock from coincidence detector
`timescale 1ns/1ns
`include "vcs_consts.svh"

module vcs_top
(
  input  wire logic                core_clk,        // 250 MHz clock
  input  wire logic                srst,            // Sync reset, active high
  input  wire logic                line_tick,       // One pulse per line
  input  wire logic                sample_en,       // Sync sample strobe
  input  wire logic                csync,           // Composite sync, high = sync
  input  wire logic                h_coinc_ok,      // H coincidence detector ok
  input  wire logic                beam_thr1,       // Beam threshold 1 crossed
  input  wire logic                beam_thr2,       // Beam threshold 2 crossed
  input  wire vcs_pkg::vcs_ctrl_t  ctrl,            // Host control bits
  input  wire logic                geo_wr,          // Geometry latch write strobe
  input  wire logic [2:0]          geo_sel,         // Geometry latch index
  input  wire logic [5:0]          geo_data,        // Geometry word
  output vcs_pkg::vcs_status_t     status,          // Host status flags
  output vcs_pkg::vcs_geo_t        geo,             // Geometry latches
  output logic [6:0]               ramp_height,     // Scaled ramp height
  output logic                     v_reset,         // Vertical reset pulse
  output logic                     v_blank,         // Vertical blanking
  output logic                     field_odd,       // Field parity
  output logic                     interlace_on,    // Half-line offset enable
  output logic [3:0]               coin_count       // Coincidence counter
);
  import vcs_pkg::*;

  logic [7:0]  sep_cnt;
  logic        vsync_lvl;
  logic        vsync_lvl_d;
  logic        vsync_ev;
  logic [9:0]  line_cnt;
  vcs_state_t  state;
  logic        hit;
  logic [9:0]  lim_min;
  logic [9:0]  lim_max;
  logic [9:0]  n525;
  logic [9:0]  n625;
  logic [9:0]  n_std;
  logic [9:0]  n_fixed;
  logic        field_end;
  logic        eval;
  logic        coinc;
  logic        match525;
  logic        match625;
  logic        std525_now;
  logic [9:0]  h_scaled;
  logic [9:0]  h_final;
  logic [5:0]  latch [0:`VCS_GEO_COUNT-1];

  // Up/down separator; saturating so noise cannot wrap it into a false sync
  always_ff @(posedge core_clk)
  begin
    if (srst)
      sep_cnt <= 8'h00;
    else if (sample_en)
    begin
      if (csync && sep_cnt != `VCS_SEP_MAX)
        sep_cnt <= sep_cnt + 8'h01;
      else if (!csync && sep_cnt != 8'h00)
        sep_cnt <= sep_cnt - 8'h01;
    end
  end

  // Threshold decode; short line syncs never climb this high
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      vsync_lvl   <= 1'b0;
      vsync_lvl_d <= 1'b0;
    end
    else
    begin
      vsync_lvl   <= (sep_cnt > `VCS_SEP_THRESH);
      vsync_lvl_d <= vsync_lvl;
    end
  end

  assign vsync_ev = vsync_lvl & ~vsync_lvl_d;

  // End-stops and standard counts, halved in double-rate mode
  always_comb
  begin
    if (ctrl.double_rate)
    begin
      lim_min = `VCS_WIN_MIN_2X;
      lim_max = `VCS_WIN_MAX_2X;
      n525    = `VCS_STD_525_2X;
      n625    = `VCS_STD_625_2X;
    end
    else
    begin
      lim_min = `VCS_WIN_MIN;
      lim_max = `VCS_WIN_MAX;
      n525    = `VCS_STD_525;
      n625    = `VCS_STD_625;
    end
    n_std   = status.std_525 ? n525 : n625;
    n_fixed = ctrl.force_525 ? n525 : n625;
  end

  // Coincidence window covers the last line and the tick that ends it
  assign match525 = (line_cnt == n525) || (line_cnt == n525 - 10'd1);
  assign match625 = (line_cnt == n625) || (line_cnt == n625 - 10'd1);

  // Field end and coincidence evaluation per mode; >= lets a count cut short mid-field still end it
  always_comb
  begin
    field_end  = 1'b0;
    eval       = 1'b0;
    coinc      = 1'b0;
    std525_now = status.std_525;
    case (state)
      VCS_ST_FORCED:
      begin
        field_end = line_tick && (line_cnt >= n_fixed - 10'd1);
      end
      VCS_ST_COUNTDOWN:
      begin
        field_end = line_tick && (line_cnt >= n_std - 10'd1);
        eval      = field_end;
        coinc     = hit || (vsync_ev && (line_cnt == n_std - 10'd1));
      end
      VCS_ST_INJECT:
      begin
        if (vsync_ev && line_cnt >= lim_min)
        begin
          field_end  = 1'b1;
          eval       = 1'b1;
          coinc      = match525 || match625;
          std525_now = match525 ? 1'b1 : (match625 ? 1'b0 : status.std_525);
        end
        else if (line_tick && line_cnt >= lim_max - 10'd1)
        begin
          field_end = 1'b1;
          eval      = 1'b1;
        end
      end
      default:
      begin
        field_end = 1'b0;
      end
    endcase
  end

  // Line counter, advanced on each line_tick
  always_ff @(posedge core_clk)
  begin
    if (srst)
      line_cnt <= 10'd0;
    else if (field_end)
      line_cnt <= 10'd0;
    else if (line_tick && line_cnt != 10'h3FF)
      line_cnt <= line_cnt + 10'd1;
  end

  // Sync seen at the field boundary; it trails the counted end tick by a cycle or two,
  // so sync in line 0 (or the captured sync at countdown entry) credits the field that starts there
  always_ff @(posedge core_clk)
  begin
    if (srst)
      hit <= 1'b0;
    else if (field_end)
      hit <= vsync_ev;
    else if (vsync_ev && (line_cnt == n_std - 10'd1 || line_cnt == 10'd0))
      hit <= 1'b1;
  end

  // Coincidence counter, saturating between zero and eight
  always_ff @(posedge core_clk)
  begin
    if (srst || ctrl.force_inject)
      coin_count <= `VCS_COIN_ZERO;
    else if (eval && ctrl.auto_countdown)
    begin
      if (coinc && coin_count != `VCS_COIN_FULL)
        coin_count <= coin_count + 4'h1;
      else if (!coinc && coin_count != `VCS_COIN_ZERO)
        coin_count <= coin_count - 4'h1;
    end
  end

  // Mode control; forcing wins over auto, auto always enters via injection lock
  always_ff @(posedge core_clk)
  begin
    if (srst)
      state <= VCS_ST_INJECT;
    else if (ctrl.force_625 || ctrl.force_525)
      state <= VCS_ST_FORCED;
    else if (ctrl.force_inject || !ctrl.auto_countdown)
      state <= VCS_ST_INJECT;
    else
    begin
      case (state)
        VCS_ST_INJECT:
        begin
          if (eval && coinc && coin_count >= `VCS_COIN_FULL - 4'h1)
            state <= VCS_ST_COUNTDOWN;
        end
        VCS_ST_COUNTDOWN:
        begin
          if (eval && !coinc && coin_count == `VCS_COIN_ZERO + 4'h1)
            state <= VCS_ST_INJECT;
        end
        VCS_ST_FORCED:
          state <= VCS_ST_INJECT;
        default:
          state <= VCS_ST_INJECT;
      endcase
    end
  end

  // Status flags; beam flags follow the comparators so the host sees live state
  always_ff @(posedge core_clk)
  begin
    if (srst)
      status <= '0;
    else
    begin
      status.countdown_lock <= coin_count[3];
      status.countdown_mode <= (state == VCS_ST_COUNTDOWN);
      status.beam_excess    <= beam_thr1;
      status.beam_overload  <= beam_thr2;
      if (eval && coinc)
        status.std_525 <= std525_now;
      if (line_tick)
        status.h_unlock <= ~h_coinc_ok;
    end
  end

  // Vertical reset, blanking and field parity
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      v_reset      <= 1'b0;
      v_blank      <= 1'b0;
      field_odd    <= 1'b0;
      interlace_on <= 1'b1;
    end
    else
    begin
      v_reset      <= field_end;
      v_blank      <= field_end ||
                      (line_cnt < (ctrl.blank_525 ? `VCS_BLANK_525 : `VCS_BLANK_625));
      interlace_on <= !(ctrl.interlace_suppress_a || ctrl.interlace_suppress_b);
      if (field_end)
        field_odd <= interlace_on ? ~field_odd : 1'b0;
    end
  end

  // Geometry latches, one per adjustment, written by index
  genvar gi;
  generate
    for (gi = 0; gi < `VCS_GEO_COUNT; gi = gi + 1)
    begin : g_geo
      always_ff @(posedge core_clk)
      begin
        if (srst)
          latch[gi] <= 6'h00;
        else if (geo_wr && geo_sel == 3'(gi))
          latch[gi] <= geo_data;
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (srst)
      geo <= '0;
    else
    begin
      geo.amplitude    <= latch[0];
      geo.linearity    <= latch[1];
      geo.breathing    <= latch[2];
      geo.position     <= latch[3];
      geo.parabola_amp <= latch[4];
      geo.corner       <= latch[5];
      geo.tilt         <= latch[6];
    end
  end

  // Ramp height: 525 gain then widescreen compression; the two truncations can lose more than one step
  always_comb
  begin
    h_scaled = {4'h0, latch[`VCS_GEO_HEIGHT]};
    if (status.std_525)
      h_scaled = (h_scaled * `VCS_H525_NUM) / `VCS_H525_DEN;
    h_final = h_scaled;
    if (ctrl.vertical_compress_select)
      h_final = (h_scaled * `VCS_CMP_NUM) >> `VCS_CMP_SHIFT;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      ramp_height <= 7'h00;
    else
      ramp_height <= h_final[6:0];
  end

endmodule

//--- vcs_chk.sv
`timescale 1ns/1ns
module vcs_chk
(
  input wire logic                core_clk,     // Clock
  input wire logic                srst,         // Reset
  input wire logic                line_tick,    // Line pulse
  input wire logic                h_coinc_ok,   // H aligned
  input wire logic                beam_thr1,    // Threshold 1
  input wire logic                beam_thr2,    // Threshold 2
  input wire vcs_pkg::vcs_ctrl_t   ctrl,         // Control
  input wire logic                geo_wr,       // Geo write
  input wire logic [2:0]          geo_sel,      // Geo index
  input wire logic [5:0]          geo_data,     // Geo word
  input wire vcs_pkg::vcs_status_t status,       // Flags
  input wire vcs_pkg::vcs_geo_t    geo,          // Latches
  input wire logic                interlace_on, // Interlace
  input wire logic [3:0]          coin_count    // Coincidence
);
  import vcs_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // Height write, and a threshold held long enough to register
  sequence s_wr0;
    geo_wr && geo_sel == 3'h0;
  endsequence
  sequence s_hot;
    beam_thr1 [*3];
  endsequence
  // Overrides may clear the counter, so only free steps are checked
  property p_step;
    $changed(coin_count) && !$past(ctrl.force_inject | ctrl.force_625 | ctrl.force_525) |->
      coin_count <= 4'h8 && (coin_count == $past(coin_count) + 4'h1 || coin_count == $past(coin_count) - 4'h1);
  endproperty
  property p_ilace;
    1'b1 |=> interlace_on == !($past(ctrl.interlace_suppress_a) | $past(ctrl.interlace_suppress_b));
  endproperty
  AST_LOCK_MSB: assert property (1'b1 |=> status.countdown_lock == $past(coin_count[3]))
    else $error("lock flag off coin MSB");
  AST_FORCE_INJ: assert property (ctrl.force_inject |=> coin_count == 4'h0 ##1 !status.countdown_mode)
    else $error("forced injection lock ignored");
  AST_COIN_STEP: assert property (p_step)
    else $error("coin count jumped");
  AST_INTERLACE: assert property (p_ilace)
    else $error("interlace select wrong");
  AST_EXCESS: assert property (s_hot |-> status.beam_excess)
    else $error("excess flag missing");
  AST_OVERLOAD: assert property (beam_thr2 [*3] |-> status.beam_overload)
    else $error("overload flag missing");
  AST_H_UNLOCK: assert property (line_tick && !h_coinc_ok |-> ##[1:2] status.h_unlock)
    else $error("h unlock flag missing");
  AST_GEO_HEIGHT: assert property (s_wr0 |-> ##2 geo.amplitude == $past(geo_data, 2))
    else $error("height latch not written");
endmodule

bind vcs_top vcs_chk u_chk
(
  .core_clk(core_clk), .srst(srst), .line_tick(line_tick), .h_coinc_ok(h_coinc_ok),
  .beam_thr1(beam_thr1), .beam_thr2(beam_thr2), .ctrl(ctrl), .geo_wr(geo_wr),
  .geo_sel(geo_sel), .geo_data(geo_data), .status(status), .geo(geo),
  .interlace_on(interlace_on), .coin_count(coin_count)
);

//--- vcs_host.sv
`timescale 1ns/1ns
module vcs_host
(
  input  wire logic                core_clk,     // Clock
  input  wire logic                srst,         // Reset
  input  wire logic                chan_change,  // Channel change request
  input  wire logic                v_reset,      // Device field end
  input  wire vcs_pkg::vcs_status_t status,       // Device flags
  output logic                     force_inject, // Jump to injection lock
  output logic                     signal_ok     // Valid signal present
);
  import vcs_pkg::*;
  // Either timebase lock alone proves a signal
  assign signal_ok = status.countdown_lock | ~status.h_unlock;
  // Force injection lock over a channel change; release once a field is captured
  always_ff @(posedge core_clk)
  begin
    if (srst)
      force_inject <= 1'b0;
    else if (chan_change)
      force_inject <= 1'b1;
    else if (v_reset)
      force_inject <= 1'b0;
  end
endmodule

//--- test_vertical_countdown_sync.sv
`timescale 1ns/1ns
module test_vertical_countdown_sync;
  import vcs_pkg::*;
  logic        core_clk = 1'b0, srst = 1'b1, line_tick = 1'b0, sample_en = 1'b0, csync = 1'b0;
  logic        h_coinc_ok = 1'b1, beam_thr1 = 1'b0, beam_thr2 = 1'b0, geo_wr = 1'b0, chg = 1'b0;
  logic [2:0]  geo_sel = 3'h0, s;
  logic [5:0]  geo_data = 6'h00, d;
  logic [1:0]  ph = 2'h0;
  logic [9:0]  n, b;
  logic [31:0] rs = 32'h00014978, r;
  logic [41:0] gm = 42'h0;
  vcs_ctrl_t   ctrl = '0;
  vcs_status_t status;
  vcs_geo_t    geo;
  logic [6:0]  ramp_height;
  logic [3:0]  coin_count;
  logic        v_reset, v_blank, field_odd, interlace_on, fi, sig_ok, fo;
  int          ln = 0, src = 625, fail_count = 0, checks_done = 0;

  always #2 core_clk = ~core_clk;

  vcs_top DUT (.core_clk(core_clk), .srst(srst), .line_tick(line_tick), .sample_en(sample_en),
    .csync(csync), .h_coinc_ok(h_coinc_ok), .beam_thr1(beam_thr1), .beam_thr2(beam_thr2),
    .ctrl(ctrl | {1'b0, fi, 7'h00}), .geo_wr(geo_wr), .geo_sel(geo_sel), .geo_data(geo_data),
    .status(status), .geo(geo), .ramp_height(ramp_height), .v_reset(v_reset), .v_blank(v_blank),
    .field_odd(field_odd), .interlace_on(interlace_on), .coin_count(coin_count));
  vcs_host u_host (.core_clk(core_clk), .srst(srst), .chan_change(chg), .v_reset(v_reset),
    .status(status), .force_inject(fi), .signal_ok(sig_ok));

  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Truncating, as the ramp DAC only keeps whole steps
  function logic [41:0] exp_ramp(logic [5:0] h, logic cmp);
    logic [9:0] v;
    v = {4'h0, h} * 10'h006 / 10'h005;
    if (cmp)
      v = (v * 10'h003) >> 2;
    return {35'h0, v[6:0]};
  endfunction
  function logic [41:0] exp_len(logic f525, logic dbl);
    return f525 ? (dbl ? 42'h106 : 42'h20D) : (dbl ? 42'h138 : 42'h271);
  endfunction

  // Three cycles a line; sync sources send broad pulses over lines 0..149, else noise
  always @(posedge core_clk)
  begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    line_tick <= (ph == 2'h2);
    sample_en <= (ph != 2'h0);
    if (ph == 2'h2)
      ln <= (ln + 1 >= src) ? 0 : ln + 1;
    csync <= (src != 0) ? (ln < 150) : (rnd() % 4 == 0);
  end

  task chk(string what, logic [41:0] seen, logic [41:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Lines and blanked lines from one field end to the next; returns in the v_reset cycle
  // so no tick is lost between fields; bounded so a lost field cannot hang
  task fields(int c);
    int k;
    repeat (c)
    begin
      n = 10'h000;
      b = 10'h000;
      k = 0;
      do
      begin
        @(negedge core_clk);
        k++;
        if (line_tick)
          n++;
        if (line_tick && v_blank)
          b++;
      end
      while (v_reset !== 1'b1 && k < 5000);
      if (v_reset !== 1'b1)
      begin
        fail_count++;
        test_done();
      end
    end
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    ctrl.auto_countdown <= 1'b1;
    @(negedge core_clk);
    chk("mode", status.countdown_mode, 0);
    fields(10);
    chk("coin", coin_count, 8);
    chk("lock", status.countdown_lock, 1);
    chk("mode", status.countdown_mode, 1);
    src = 0;
    fields(2);
    chk("cd len", n, 42'h271);
    fields(8);
    chk("mode", status.countdown_mode, 0);
    fields(1);
    chk("stop len", n, 42'h2E4);
    $display("countdown test done");
    src = 300;
    fields(4);
    chk("window len", n, 42'h258);
    src = 525;
    fields(4);
    chk("std", status.std_525, 1);
    // All eight indices in turn, then random ones; index 7 must change nothing
    for (int i = 0; i < 16; i++)
    begin
      @(posedge core_clk);
      r = rnd();
      d = (i == 0) ? 6'h3F : r[5:0];
      s = (i < 8) ? i[2:0] : r[8:6];
      geo_wr <= 1'b1;
      geo_sel <= s;
      geo_data <= d;
      ctrl.vertical_compress_select <= r[9];
      @(posedge core_clk);
      geo_wr <= 1'b0;
      repeat (3) @(negedge core_clk);
      if (s != 3'h7)
        gm[6 * s +: 6] = d;
      chk("geo", geo, gm);
      chk("ramp", ramp_height, exp_ramp(gm[5:0], r[9]));
    end
    $display("geometry test done");
    @(posedge core_clk);
    chg <= 1'b1;
    @(posedge core_clk);
    chg <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("coin", coin_count, 0);
    chk("mode", status.countdown_mode, 0);
    src = 500;
    fields(2);
    for (int j = 0; j < 4; j++)
    begin
      @(posedge core_clk);
      ctrl.force_525 <= j[0];
      ctrl.force_625 <= !j[0];
      ctrl.double_rate <= j[1];
      ctrl.blank_525 <= j[0] ^ j[1];
      fields(2);
      chk("forced len", n, exp_len(j[0], j[1]));
      chk("blank", b, (j[0] ^ j[1]) ? 42'h14 : 42'h19);
      fo = field_odd;
      fields(1);
      chk("parity", field_odd, !fo);
    end
    $display("forced count test done");
    for (int j = 0; j < 12; j++)
    begin
      @(posedge core_clk);
      r = rnd();
      beam_thr1 <= r[0];
      beam_thr2 <= r[1];
      h_coinc_ok <= r[2];
      ctrl.interlace_suppress_a <= r[3];
      ctrl.interlace_suppress_b <= r[4];
      repeat (12) @(negedge core_clk);
      chk("excess", status.beam_excess, r[0]);
      chk("overload", status.beam_overload, r[1]);
      chk("h unlock", status.h_unlock, !r[2]);
      chk("interlace", interlace_on, !(r[3] | r[4]));
      chk("signal", sig_ok, r[2]);
    end
    $display("flag test done");
    test_done();
  end
endmodule
